// >>> include/nvm_cmd_pkg.sv
// constants, command codes and register map of the nonvolatile command front end
package nvm_cmd_pkg;
  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_PROT = 4'h1;
  localparam logic [3:0] IDX_STAT = 4'h2;
  localparam logic [3:0] IDX_IEN = 4'h3;
  localparam logic [3:0] IDX_IFLG = 4'h4;
  localparam logic [3:0] IDX_DATL = 4'h6;
  localparam logic [3:0] IDX_DATH = 4'h7;
  localparam logic [3:0] IDX_ADRL = 4'h8;
  localparam logic [3:0] IDX_ADRH = 4'h9;
  localparam int ADR_W = 6;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIT_APPGUARD = 0;
  localparam int BIT_BOOT_REGION_LOCK = 1;
  localparam int BIT_CODEBUSY = 0;
  localparam int BIT_NVDBUSY = 1;
  localparam int BIT_WFAULT = 2;
  localparam int BIT_IDLEIRQ = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ****************************************
  // timing
  // ****************************************
  localparam logic [2:0] KEY_WINDOW = 3'h4;
  localparam logic [2:0] LATCH_RESET_CYCLES = 3'h7;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] NVD_LO = 16'h1400;
  localparam logic [15:0] NVD_HI = 16'h14ff;
  localparam logic [15:0] BOOT_LO = 16'h8000;
  localparam logic [15:0] BOOT_HI = 16'h81ff;
  localparam logic [15:0] APP_HI = 16'hbfff;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_PAGE_WIPE = 3'h2,
    OP_WIPE_PROGRAM = 3'h3,
    OP_LATCH_RESET = 3'h4,
    OP_WHOLE_WIPE = 3'h5,
    OP_NVDATA_WIPE = 3'h6,
    OP_FUSE_PROGRAM = 3'h7
  } op_t;
  typedef enum logic [1:0] {
    SLP_IDLE = 2'h0,
    SLP_STANDBY = 2'h1,
    SLP_PDOWN = 2'h2
  } sleep_t;
endpackage : nvm_cmd_pkg

// >>> include/nvm_op_if.sv
// command hand-off between the register front end and the operation engine
`timescale 1ns/1ps
interface nvm_op_if;
  import nvm_cmd_pkg::*;
  logic start;
  op_t op;
  logic toCode;
  logic toNvd;
  logic busyCode;
  logic busyNvd;
  logic finish;
  modport ctl (output start, op, toCode, toNvd, input busyCode, busyNvd, finish);
  modport eng (input start, op, toCode, toNvd, output busyCode, busyNvd, finish);
endinterface : nvm_op_if

// >>> rtl/nvm_op_engine.sv
// operation engine: runs one accepted command and reports busy and finish
`timescale 1ns/1ps
module nvm_op_engine
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command side
  nvm_op_if.eng opIf,
  // array side
  output logic arrayStart,
  output nvm_cmd_pkg::op_t arrayOp,
  input wire logic arrayDone
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_ARRAY, ENG_LATCH} eng_t;
  eng_t state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic start_ff, busyC_ff, busyN_ff, fin_ff;
  op_t op_ff;
  wire isLatch = (opIf.op == OP_LATCH_RESET);
  wire lastTick = (state_ff == ENG_LATCH) && (cnt_ff == 3'h1);
  wire arrEnd = (state_ff == ENG_ARRAY) && arrayDone;
  wire ending = lastTick || arrEnd;
  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ENG_IDLE: begin
        if (opIf.start && isLatch) begin
          nxt_state = ENG_LATCH;
          nxt_cnt = LATCH_RESET_CYCLES;
        end else if (opIf.start) begin
          nxt_state = ENG_ARRAY;
        end
      end
      ENG_LATCH: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (lastTick) nxt_state = ENG_IDLE;
      end
      ENG_ARRAY: begin
        if (arrayDone) nxt_state = ENG_IDLE;
      end
      default: nxt_state = ENG_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ENG_IDLE;
      cnt_ff <= 3'h0;
      start_ff <= 1'b0;
      op_ff <= OP_NONE;
      busyC_ff <= 1'b0;
      busyN_ff <= 1'b0;
      fin_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      start_ff <= opIf.start && !isLatch && (state_ff == ENG_IDLE);
      if (opIf.start && (state_ff == ENG_IDLE)) op_ff <= opIf.op;
      busyC_ff <= (opIf.start && (state_ff == ENG_IDLE)) ? opIf.toCode : (busyC_ff && !ending);
      busyN_ff <= (opIf.start && (state_ff == ENG_IDLE)) ? opIf.toNvd : (busyN_ff && !ending);
      fin_ff <= ending;
    end
  end
  assign arrayStart = start_ff;
  assign arrayOp = op_ff;
  assign opIf.busyCode = busyC_ff;
  assign opIf.busyNvd = busyN_ff;
  assign opIf.finish = fin_ff;
  // ****************************************
  // checks
  // ****************************************
  AST_LATCH_SEVEN: assert property (@(posedge clk) disable iff (!rstn) // [R07]
    (opIf.start && isLatch && state_ff == ENG_IDLE) |=> busyC_ff[*7] ##1 (fin_ff && !busyC_ff))
    else $error("latch reset did not take seven cycles");
  COV_ARRAY_OP: cover property (@(posedge clk) disable iff (!rstn) start_ff ##[1:50] fin_ff);
endmodule : nvm_op_engine

// >>> rtl/nvm_command_protection_ctrl.sv
// register front end of the nonvolatile controller: guarded commands, locks, status, sleep
//
// What this block does
// [R01] no write running: sleep with system
// [R02] write running: keep array, clock on
// [R03] idle-irq wakes from idle sleep only
// [R04] wake-up clears the page latch
// [R05] command write needs key within four instructions
// [R06] unkeyed command write acked, value unchanged
// [R07] three-bit op code decodes seven commands
// [R08] page ops pick target from address register
// [R09] fuse program only from debug port
// [R10] whole wipe spares data if keep-fuse set
// [R11] locked boot region reads back zero
// [R12] boot lock set only from boot code
// [R13] boot lock acts after leaving boot region
// [R14] app guard set-only, blocks app writes
// [R15] write fault shows last operation failed
// [R16] two busy bits: data and code
// [R17] ready flag cleared by writing one
// [R18] ready irq level, requests while data idle
// [R19] software enables irq after command only
// [R20] data register holds fuse value
// [R21] address register tracks last updated location
// [R22] code program stalls core, data does not
// [R23] debug loads address, data before fuse
// [R24] ready flag sets when data busy falls
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module nvm_command_protection_ctrl
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nvm_cmd_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire logic busFromDebug,
  input wire logic keyWritten,
  input wire logic instrDone,
  input wire logic fetchInBoot,
  output logic coreStall,
  // memory read path and page latch stores
  input wire logic memRdEn,
  input wire logic [15:0] memRdAddr,
  input wire logic [7:0] arrayRdata,
  output logic [7:0] memRdata,
  input wire logic pbufWr,
  input wire logic [15:0] pbufAddr,
  output logic pbufClear,
  // array engine
  output logic arrayStart,
  output nvm_cmd_pkg::op_t arrayOp,
  output logic [15:0] arrayAddr,
  output logic [15:0] fuseValue,
  input wire logic arrayDone,
  input wire logic keepNvdataOnWipe,
  // sleep
  input wire logic sleepReq,
  input wire nvm_cmd_pkg::sleep_t sleepMode,
  output logic ctrlAsleep,
  output logic clkHold,
  output logic wakeReq,
  // ready interrupt
  output logic nvdataIrq
);
  import nvm_cmd_pkg::*;
  nvm_op_if opIf ();
  // ****************************************
  // state
  // ****************************************
  logic ack_ff;
  logic [31:0] datOut_ff;
  logic [2:0] keyWin_ff;
  logic start_ff;
  op_t op_ff;
  logic toCode_ff, toNvd_ff;
  logic guard_ff, lockPend_ff, lockOn_ff;
  logic fault_ff;
  logic ien_ff, flag_ff;
  logic [15:0] data_ff, addr_ff;
  logic busyN_d_ff;
  logic pbHas_ff, pbSect_ff, pbMix_ff;
  logic pbClr_ff;
  logic asleep_ff, clkHold_ff, wake_ff, irq_ff, stall_ff;
  logic [7:0] rdOut_ff;
  // ****************************************
  // bus decode
  // ****************************************
  wire req = wb_cyc_i && wb_stb_i;
  wire [3:0] idx = wb_adr_i[ADR_W-1:2];
  wire wrEn = req && wb_we_i && ack_ff && wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wrCmd = wrEn && (idx == IDX_CMD);
  wire wrProt = wrEn && (idx == IDX_PROT);
  wire wrIen = wrEn && (idx == IDX_IEN);
  wire wrFlg = wrEn && (idx == IDX_IFLG);
  wire wrDatL = wrEn && (idx == IDX_DATL);
  wire wrDatH = wrEn && (idx == IDX_DATH);
  wire wrAdrL = wrEn && (idx == IDX_ADRL);
  wire wrAdrH = wrEn && (idx == IDX_ADRH);
  // ****************************************
  // address classification
  // ****************************************
  wire addrNvd = (addr_ff >= NVD_LO) && (addr_ff <= NVD_HI);
  wire addrBoot = (addr_ff >= BOOT_LO) && (addr_ff <= BOOT_HI);
  wire addrApp = (addr_ff > BOOT_HI) && (addr_ff <= APP_HI);
  wire pbNvd = (pbufAddr >= NVD_LO) && (pbufAddr <= NVD_HI);
  wire rdBoot = (memRdAddr >= BOOT_LO) && (memRdAddr <= BOOT_HI);
  // ****************************************
  // command decode and acceptance
  // ****************************************
  op_t wop;
  assign wop = op_t'(wd[2:0]);
  wire keyOk = (keyWin_ff != 3'h0) || busFromDebug;
  wire busyAny = opIf.busyCode || opIf.busyNvd;
  wire engBusy = busyAny || start_ff;
  wire pageOp = (wop == OP_PROGRAM) || (wop == OP_PAGE_WIPE) || (wop == OP_WIPE_PROGRAM);
  wire protHit = (addrApp && guard_ff) || (addrBoot && lockOn_ff);
  wire progMix = (wop != OP_PAGE_WIPE) && pbMix_ff;
  wire badPage = pageOp && (protHit || progMix);
  wire badFuse = (wop == OP_FUSE_PROGRAM) && !busFromDebug;
  wire cmdTake = wrCmd && keyOk && (wop != OP_NONE);
  wire cmdBad = engBusy || badPage || badFuse;
  wire cmdGo = cmdTake && !cmdBad;
  logic nxtToCode, nxtToNvd;
  always_comb begin
    nxtToCode = 1'b1;
    nxtToNvd = 1'b0;
    case (wop)
      OP_PROGRAM, OP_PAGE_WIPE, OP_WIPE_PROGRAM: begin
        nxtToCode = !addrNvd; // [R08]
        nxtToNvd = addrNvd; // [R08]
      end
      OP_WHOLE_WIPE: begin
        nxtToCode = 1'b1;
        nxtToNvd = !keepNvdataOnWipe; // [R10]
      end
      OP_NVDATA_WIPE: begin
        nxtToCode = 1'b0;
        nxtToNvd = 1'b1;
      end
      default: begin
        nxtToCode = 1'b1;
        nxtToNvd = 1'b0;
      end
    endcase
  end
  // ****************************************
  // key window: four retired instructions
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      keyWin_ff <= 3'h0;
    end else if (keyWritten) begin
      keyWin_ff <= KEY_WINDOW; // [R05]
    end else if (wrCmd) begin
      keyWin_ff <= 3'h0;
    end else if (instrDone && keyWin_ff != 3'h0) begin
      keyWin_ff <= keyWin_ff - 3'h1; // [R05]
    end
  end
  // ****************************************
  // command issue and fault
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_ff <= 1'b0;
      op_ff <= OP_NONE;
      toCode_ff <= 1'b0;
      toNvd_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      start_ff <= cmdGo; // [R06] [R09]
      if (cmdGo) begin
        op_ff <= wop; // [R07]
        toCode_ff <= nxtToCode;
        toNvd_ff <= nxtToNvd;
      end
      if (cmdTake) fault_ff <= cmdBad; // [R15]
    end
  end
  assign opIf.start = start_ff;
  assign opIf.op = op_ff;
  assign opIf.toCode = toCode_ff;
  assign opIf.toNvd = toNvd_ff;
  nvm_op_engine engine (
    .clk(clk),
    .rstn(rstn),
    .opIf(opIf.eng),
    .arrayStart(arrayStart),
    .arrayOp(arrayOp),
    .arrayDone(arrayDone)
  );
  // ****************************************
  // region protection
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      guard_ff <= 1'b0;
      lockPend_ff <= 1'b0;
      lockOn_ff <= 1'b0;
    end else begin
      if (wrProt && wd[BIT_APPGUARD]) guard_ff <= 1'b1; // [R14]
      if (wrProt && wd[BIT_BOOT_REGION_LOCK] && fetchInBoot && !busFromDebug) lockPend_ff <= 1'b1; // [R12]
      if (lockPend_ff && !fetchInBoot) lockOn_ff <= 1'b1; // [R13]
    end
  end
  // locked boot reads give zero; a fetched zero is the no-op opcode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdOut_ff <= RST_BYTE;
    end else if (memRdEn) begin
      rdOut_ff <= (rdBoot && lockOn_ff) ? 8'h00 : arrayRdata; // [R11]
    end
  end
  // ****************************************
  // data and address registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_ff <= RST_WORD;
      addr_ff <= RST_WORD;
    end else begin
      if (wrDatL) data_ff[7:0] <= wd; // [R20]
      if (wrDatH) data_ff[15:8] <= wd; // [R20]
      // a store into the latch outranks a bus write in the same cycle
      if (pbufWr) begin
        addr_ff <= pbufAddr; // [R21]
      end else begin
        if (wrAdrL) addr_ff[7:0] <= wd;
        if (wrAdrH) addr_ff[15:8] <= wd;
      end
    end
  end
  // ****************************************
  // page latch section tracking
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pbHas_ff <= 1'b0;
      pbSect_ff <= 1'b0;
      pbMix_ff <= 1'b0;
    end else if (pbClr_ff) begin
      pbHas_ff <= 1'b0;
      pbMix_ff <= 1'b0;
    end else if (pbufWr) begin
      pbHas_ff <= 1'b1;
      if (!pbHas_ff) pbSect_ff <= pbNvd;
      if (pbHas_ff && pbSect_ff != pbNvd) pbMix_ff <= 1'b1; // [R15]
    end
  end
  // ****************************************
  // ready flag and interrupt
  // ****************************************
  wire nvdFell = busyN_d_ff && !opIf.busyNvd;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyN_d_ff <= 1'b0;
      ien_ff <= 1'b0;
      flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      busyN_d_ff <= opIf.busyNvd;
      if (wrIen) ien_ff <= wd[BIT_IDLEIRQ];
      // a completion in the clearing cycle keeps the flag set
      flag_ff <= nvdFell || (flag_ff && !(wrFlg && wd[BIT_IDLEIRQ])); // [R17] [R24]
      irq_ff <= ien_ff && !opIf.busyNvd; // [R18]
    end
  end
  // ****************************************
  // sleep, wake and stall
  // ****************************************
  wire waking = asleep_ff && !sleepReq;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asleep_ff <= 1'b0;
      clkHold_ff <= 1'b0;
      wake_ff <= 1'b0;
      pbClr_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      asleep_ff <= sleepReq && !busyAny; // [R01]
      clkHold_ff <= sleepReq && busyAny; // [R02]
      wake_ff <= sleepReq && (sleepMode == SLP_IDLE) && ien_ff && !opIf.busyNvd; // [R03]
      pbClr_ff <= waking || opIf.finish; // [R04]
      stall_ff <= opIf.busyCode; // [R22]
    end
  end
  // ****************************************
  // register read
  // ****************************************
  logic [7:0] rdByte;
  always_comb begin
    case (idx)
      IDX_CMD: rdByte = {5'h00, op_ff};
      IDX_PROT: rdByte = {6'h00, lockPend_ff, guard_ff};
      IDX_STAT: rdByte = {5'h00, fault_ff, opIf.busyNvd, opIf.busyCode}; // [R16]
      IDX_IEN: rdByte = {7'h00, ien_ff};
      IDX_IFLG: rdByte = {7'h00, flag_ff};
      IDX_DATL: rdByte = data_ff[7:0];
      IDX_DATH: rdByte = data_ff[15:8];
      IDX_ADRL: rdByte = addr_ff[7:0];
      IDX_ADRH: rdByte = addr_ff[15:8];
      default: rdByte = 8'h00;
    endcase
  end
  // one wait state: ack follows the request by one clock, data with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      datOut_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff) datOut_ff <= {24'h00_0000, rdByte};
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = datOut_ff;
  assign coreStall = stall_ff;
  assign memRdata = rdOut_ff;
  assign pbufClear = pbClr_ff;
  assign arrayAddr = addr_ff;
  assign fuseValue = data_ff;
  assign ctrlAsleep = asleep_ff;
  assign clkHold = clkHold_ff;
  assign wakeReq = wake_ff;
  assign nvdataIrq = irq_ff;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_NO_KEY: assert property ((wrCmd && !keyOk) |=> !start_ff ##1 !arrayStart) // [R06]
    else $error("unkeyed command started an operation");
  AST_KEY_GO: assert property ((wrCmd && keyOk && wop == OP_PROGRAM && !cmdBad) |=> start_ff ##1 arrayStart) // [R05]
    else $error("keyed program command did not start");
  AST_FUSE_CORE: assert property ((wrCmd && keyOk && wop == OP_FUSE_PROGRAM && !busFromDebug) // [R09]
    |=> !start_ff && fault_ff)
    else $error("core started fuse program");
  AST_WIPE_KEEP: assert property ((cmdGo && wop == OP_WHOLE_WIPE && keepNvdataOnWipe) |=> ##1 !opIf.busyNvd) // [R10]
    else $error("whole wipe touched kept data");
  AST_LOCK_ZERO: assert property ((memRdEn && rdBoot && lockOn_ff) |=> memRdata == 8'h00) // [R11]
    else $error("locked boot read not zero");
  AST_LOCK_LATE: assert property ($rose(lockOn_ff) |-> $past(lockPend_ff && !fetchInBoot)) // [R13]
    else $error("boot lock acted inside boot region");
  AST_STICKY: assert property ((lockOn_ff || guard_ff) |=> (lockOn_ff || guard_ff)) // [R12]
    else $error("protection bit cleared without reset");
  AST_FLAG_SET: assert property ($fell(opIf.busyNvd) |=> flag_ff) // [R24]
    else $error("ready flag missed a completion");
  AST_W1C: assert property ((flag_ff && wrFlg && wd[0] && !nvdFell) |=> !flag_ff) // [R17]
    else $error("ready flag not cleared by one");
  AST_IRQ: assert property ((ien_ff && !opIf.busyNvd) [*2] |-> nvdataIrq) // [R18]
    else $error("idle data did not request");
  AST_HOLD: assert property ((sleepReq && busyAny) |=> clkHold && !ctrlAsleep) // [R02]
    else $error("clock dropped during a write");
  AST_WAKE: assert property (waking |=> pbufClear) // [R04]
    else $error("wake did not clear page latch");
  AST_IDLE_ONLY: assert property (wakeReq |-> $past(sleepMode) == SLP_IDLE) // [R03]
    else $error("wake from deep sleep mode");
  COV_KEYED: cover property (keyWritten ##[1:4] (wrCmd && cmdGo));
  COV_LOCK: cover property (wrProt && wd[1] && fetchInBoot ##[1:20] lockOn_ff);
  COV_SLEEP_BUSY: cover property (sleepReq && busyAny ##[1:50] ctrlAsleep);
endmodule : nvm_command_protection_ctrl

// >>> test/nvm_array_model.sv
// array model: answers each started operation with a done pulse after a delay
`timescale 1ns/1ps
module nvm_array_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // engine side
  input wire logic arrayStart,
  input wire logic slow,
  output logic arrayDone
);
  logic [5:0] cnt_ff;
  // never answers in the start cycle; slow mode leaves room to sleep mid-operation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 6'h00;
      arrayDone <= 1'b0;
    end else begin
      arrayDone <= (cnt_ff == 6'h01);
      if (arrayStart) cnt_ff <= slow ? 6'h28 : 6'h06;
      else if (cnt_ff != 6'h00) cnt_ff <= cnt_ff - 6'h01;
    end
  end
endmodule : nvm_array_model

// >>> test/nvm_command_protection_ctrl_bench.sv
// self-checking bench of the nonvolatile command front end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module nvm_command_protection_ctrl_bench;
  import nvm_cmd_pkg::*;
  logic clk, rstn, cyc, stb, we, ack, fromDbg, inBoot, stall, pbufClr;
  // one-cycle strobes towards the core side: key, retired instruction, latch store, array read
  logic [3:0] pls;
  localparam logic [3:0] P_KEY = 4'h1;
  localparam logic [3:0] P_INSTR = 4'h2;
  localparam logic [3:0] P_STORE = 4'h4;
  localparam logic [3:0] P_READ = 4'h8;
  logic aStart, aDone, keep, slp, asleep, hold, wake, irq, slow;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, datO;
  logic [15:0] memAddr, pbufAddr, aAddr, fuseVal;
  logic [7:0] memRd, arrRd, q;
  op_t aOp;
  sleep_t slpMode;
  int nErrors = 0, checkCount = 0, nStart = 0, nDone = 0, nClr = 0;
  nvm_command_protection_ctrl DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .busFromDebug(fromDbg),
    .keyWritten(pls[0]), .instrDone(pls[1]), .fetchInBoot(inBoot), .coreStall(stall), .memRdEn(pls[3]),
    .memRdAddr(memAddr), .arrayRdata(arrRd), .memRdata(memRd), .pbufWr(pls[2]), .pbufAddr(pbufAddr),
    .pbufClear(pbufClr), .arrayStart(aStart), .arrayOp(aOp), .arrayAddr(aAddr), .fuseValue(fuseVal),
    .arrayDone(aDone), .keepNvdataOnWipe(keep), .sleepReq(slp), .sleepMode(slpMode), .ctrlAsleep(asleep),
    .clkHold(hold), .wakeReq(wake), .nvdataIrq(irq));
  nvm_array_model model (.clk(clk), .rstn(rstn), .arrayStart(aStart), .slow(slow), .arrayDone(aDone));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulse counters, so no scenario can miss a one-cycle output
  always @(posedge clk) begin
    if (aStart) nStart <= nStart + 1;
    if (aDone) nDone <= nDone + 1;
    if (pbufClr) nClr <= nClr + 1;
  end
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d, output logic [7:0] r);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK("busAck", 1'b1, ack)
    r = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d, q);
  endtask : wr
  task automatic rdc(input logic [3:0] i, input logic [7:0] e, input string nm);
    bus(1'b0, i, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rdc
  task automatic pulse(input logic [3:0] m);
    pls <= m;
    @(posedge clk);
    pls <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task automatic cmd(input op_t op);
    pulse(P_KEY);
    wr(IDX_CMD, {5'h00, op});
  endtask : cmd
  // every finished operation pulses the latch clear, so that count marks completion
  task automatic waitCnt(input int n0);
    int k;
    k = 0;
    while (nClr == n0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    `CHK("opDone", 1'b1, nClr != n0)
    repeat (4) @(posedge clk);
  endtask : waitCnt
  // ordinary page latch store, which also moves the address register
  task automatic store(input logic [15:0] a);
    pbufAddr <= a;
    pulse(P_STORE);
    `CHK("addrReg", a, aAddr)
  endtask : store
  task automatic memChk(input logic [15:0] a, input logic [7:0] e);
    memAddr <= a;
    pulse(P_READ);
    `CHK("memRdata", e, memRd)
  endtask : memChk
  task automatic tReset();
    for (int i = 0; i < 10; i++) rdc(i[3:0], 8'h00, "regReset");
  endtask : tReset
  task automatic tGuard();
    int n;
    n = nStart;
    wr(IDX_CMD, {5'h00, OP_NVDATA_WIPE});
    pulse(P_KEY);
    // five retired instructions run past the four-instruction window
    repeat (5) pulse(P_INSTR);
    wr(IDX_CMD, {5'h00, OP_NVDATA_WIPE});
    repeat (6) @(posedge clk);
    `CHK("unkeyedStart", n, nStart)
    rdc(IDX_CMD, 8'h00, "unkeyedCmd");
  endtask : tGuard
  task automatic tOps();
    op_t ops[7] = '{OP_PROGRAM, OP_PAGE_WIPE, OP_WIPE_PROGRAM, OP_LATCH_RESET, OP_WHOLE_WIPE, OP_WHOLE_WIPE,
      OP_NVDATA_WIPE};
    logic [7:0] bsy[7] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h03, 8'h01, 8'h02};
    int n;
    foreach (ops[j]) begin
      store(16'h1400);
      // second whole wipe runs with the keep fuse set
      keep <= (j == 5);
      n = nClr;
      cmd(ops[j]);
      rdc(IDX_STAT, bsy[j], "opBusy");
      `CHK("arrayOp", ops[j], aOp)
      waitCnt(n);
      rdc(IDX_STAT, 8'h00, "statIdle");
    end
    `CHK("startDonePair", nStart, nDone)
  endtask : tOps
  task automatic tProgram();
    int n;
    wr(IDX_IFLG, 8'h01);
    store(16'h1400);
    slow <= 1'b1;
    n = nClr;
    cmd(OP_PROGRAM);
    rdc(IDX_STAT, 8'h02, "nvdBusy");
    `CHK("nvdStall", 1'b0, stall)
    rdc(IDX_IFLG, 8'h00, "flagWhileBusy");
    waitCnt(n);
    rdc(IDX_IFLG, 8'h01, "readyFlag");
    wr(IDX_IFLG, 8'h00);
    rdc(IDX_IFLG, 8'h01, "flagZeroWr");
    wr(IDX_IFLG, 8'h01);
    rdc(IDX_IFLG, 8'h00, "flagClear");
    store(16'h8200);
    n = nClr;
    cmd(OP_PROGRAM);
    rdc(IDX_STAT, 8'h01, "codeBusy");
    `CHK("codeStall", 1'b1, stall)
    waitCnt(n);
    slow <= 1'b0;
  endtask : tProgram
  task automatic tFuse();
    int n;
    wr(IDX_ADRL, 8'h02);
    wr(IDX_ADRH, 8'h12);
    wr(IDX_DATL, 8'h34);
    wr(IDX_DATH, 8'h12);
    `CHK("fuseValue", 16'h1234, fuseVal)
    n = nStart;
    cmd(OP_FUSE_PROGRAM);
    rdc(IDX_STAT, 8'h04, "coreFuse");
    `CHK("coreFuseStart", n, nStart)
    n = nClr;
    fromDbg <= 1'b1;
    wr(IDX_CMD, {5'h00, OP_FUSE_PROGRAM});
    fromDbg <= 1'b0;
    waitCnt(n);
    `CHK("dbgFuseOp", OP_FUSE_PROGRAM, aOp)
    rdc(IDX_STAT, 8'h00, "dbgFuseStat");
  endtask : tFuse
  task automatic tSleep();
    int n;
    store(16'h1400);
    slow <= 1'b1;
    n = nClr;
    cmd(OP_PROGRAM);
    slpMode <= SLP_PDOWN;
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("holdWhileWrite", 1'b1, hold)
    `CHK("awakeWhileWrite", 1'b0, asleep)
    waitCnt(n);
    slp <= 1'b0;
    // enabled only once a command has been issued
    wr(IDX_IEN, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("irqLevel", 1'b1, irq)
    slpMode <= SLP_STANDBY;
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("asleep", 1'b1, asleep)
    `CHK("noWakeStandby", 1'b0, wake)
    n = nClr;
    slp <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("wakeClear", n + 1, nClr)
    slpMode <= SLP_IDLE;
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("wakeIdle", 1'b1, wake)
    slp <= 1'b0;
    wr(IDX_IEN, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("irqOff", 1'b0, irq)
    slow <= 1'b0;
  endtask : tSleep
  task automatic tProtect();
    wr(IDX_PROT, 8'h02);
    rdc(IDX_PROT, 8'h00, "lockOutside");
    inBoot <= 1'b1;
    wr(IDX_PROT, 8'h02);
    wr(IDX_PROT, 8'h01);
    wr(IDX_PROT, 8'h00);
    rdc(IDX_PROT, 8'h03, "setOnly");
    memChk(16'h8010, 8'ha5);
    inBoot <= 1'b0;
    // the lock arms on the first edge outside the boot region, so the read waits one edge
    @(posedge clk);
    memChk(16'h8010, 8'h00);
    memChk(16'h1400, 8'ha5);
    store(16'h8200);
    cmd(OP_PAGE_WIPE);
    rdc(IDX_STAT, 8'h04, "guardFault");
  endtask : tProtect
  task stopTest();
    if (nErrors == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stopTest
  initial begin
    {rstn, cyc, stb, we, fromDbg, inBoot, keep, slp, slow} = '0;
    {adr, dat, memAddr, pbufAddr, pls} = '0;
    sel = 4'hf;
    arrRd = 8'ha5;
    slpMode = SLP_IDLE;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    tReset();
    tGuard();
    tOps();
    tProgram();
    tFuse();
    tSleep();
    // boot lock is sticky until reset, so it runs last
    tProtect();
    stopTest();
  end
  initial begin
    #40000;
    nErrors++;
    stopTest();
  end
endmodule : nvm_command_protection_ctrl_bench
